// >>> src/potc_pkg.sv
// Overview of operation
// - START is SDA fall while SCL high
// - STOP is SDA rise; every operation ends so
// - SDA change during SCL high means START/STOP
// - Master alone starts transfers and drives SCL
// - Address: type code above four strap bits
// - Acknowledge address only on full match
// - Receiver pulls SDA low on ninth clock
// - Acknowledge every byte of a write
// - Read: send byte, continue only if acknowledged
// - Write: address, instruction, data, then STOP
// - STOP after nonvolatile write starts programming
// - Programming up to 5 ms, bus deaf
// - Master polls address until acknowledged again
// - Write protect low blocks nonvolatile programming
// - Protected: refuse acknowledge of data byte
// - Protect before start abandons, after has no effect
// - Master waits 1 ms after power-up
// - Filter out SCL/SDA glitches under 50 ns
package potc_pkg;
  // Arbitrary device-type value
  localparam logic [3:0] TYPE_CODE     = 4'ha;
  localparam int         CLK_NS        = 10;
  localparam int         FILTER_NS     = 50;
  localparam int         FILT_CYC      = (FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int         PROG_MS       = 5;
  localparam int         PROG_CYC      = PROG_MS * 1000000 / CLK_NS;
  localparam int         PWRUP_MS      = 1;
  localparam int         PWRUP_CYC     = PWRUP_MS * 1000000 / CLK_NS;
  localparam int         SCL_NS        = 2560;
  localparam int         QTR_CYC       = SCL_NS / 4 / CLK_NS;
  // Instruction byte layout
  localparam int         INSTR_OPC_LSB = 4;
  localparam logic [3:0] OPC_RD_WCR    = 4'h9;
  localparam logic [3:0] OPC_RD_DR     = 4'hb;
  localparam logic [3:0] OPC_WR_DR     = 4'hc;
  // Master command word: op in [10:8], byte in [7:0]
  localparam int         CMD_W         = 11;
  localparam int         FIFO_DEPTH    = 8;
  localparam logic [2:0] CMD_START     = 3'h0;
  localparam logic [2:0] CMD_WRITE     = 3'h1;
  localparam logic [2:0] CMD_READ_ACK  = 3'h2;
  localparam logic [2:0] CMD_READ_NACK = 3'h3;
  localparam logic [2:0] CMD_STOP      = 3'h4;
  // Master registers
  localparam logic [3:0] REG_CMD       = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam int         ST_ACK_BIT    = 8;
  localparam int         ST_BUSY_BIT   = 9;
  localparam int         ST_EMPTY_BIT  = 10;
  localparam int         ST_READY_BIT  = 11;
  localparam int         ST_PWR_BIT    = 12;
endpackage

// >>> src/potc_bus_if.sv
`timescale 1ns/10ps
interface potc_bus_if;
  logic sclMstOut;
  logic sclMstOe;
  logic sdaMstOut;
  logic sdaMstOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;

  // Open drain with pull-up: any enabled low driver wins
  assign scl = ~(sclMstOe & ~sclMstOut);
  assign sda = ~((sdaMstOe & ~sdaMstOut) | (sdaDevOe & ~sdaDevOut));

  modport dev (input scl, input sda, output sdaDevOut, output sdaDevOe);
  modport mst (input scl, input sda, output sclMstOut, output sclMstOe,
               output sdaMstOut, output sdaMstOe);
endinterface

// >>> src/potc_dev_end.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module potc_dev_end #(
  parameter int PROG_CYCLES = potc_pkg::PROG_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Two-wire bus
  potc_bus_if.dev         bus,
  // Straps and protection
  input  wire logic       addrStrapBit0,
  input  wire logic       addrStrapBit1,
  input  wire logic       addrStrapBit2,
  input  wire logic       addrStrapBit3,
  input  wire logic       writeAllow,
  // User side
  input  wire logic [7:0] txByte,
  output logic            txTake,
  output logic [7:0]      rxInstr,
  output logic [7:0]      rxData,
  output logic            rxStrobe,
  output logic            progBusy
);
  typedef enum {DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_INSTR, DS_INSTR_ACK,
                DS_DATA, DS_DATA_ACK, DS_TX, DS_TX_ACK} potc_dstate_e;

  // ----------------------------------------
  // Input synchronisers and glitch filters
  // ----------------------------------------
  logic [1:0] rawLine;
  logic [1:0] filt;
  assign rawLine = {bus.sda, bus.scl};

  for (genvar g = 0; g < 2; g++) begin : gFilt
    logic       s1_r;
    logic       s2_r;
    logic       f_r;
    logic [2:0] c_r;
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        f_r  <= 1'b1;
        c_r  <= 3'h0;
      end else begin
        s1_r <= rawLine[g];
        s2_r <= s1_r;
        // A new level must hold for the whole filter time
        if (s2_r == f_r) begin
          c_r <= 3'h0;
        end else if (c_r == 3'(potc_pkg::FILT_CYC - 1)) begin
          f_r <= s2_r;
          c_r <= 3'h0;
        end else begin
          c_r <= c_r + 3'h1;
        end
      end
    end
    assign filt[g] = f_r;
  end

  logic [4:0] pin1_r;
  logic [4:0] pin2_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin1_r <= 5'h00;
      pin2_r <= 5'h00;
    end else begin
      pin1_r <= {writeAllow, addrStrapBit3, addrStrapBit2, addrStrapBit1, addrStrapBit0};
      pin2_r <= pin1_r;
    end
  end

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  logic sclP_r;
  logic sdaP_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclP_r <= 1'b1;
      sdaP_r <= 1'b1;
    end else begin
      sclP_r <= filt[0];
      sdaP_r <= filt[1];
    end
  end

  logic sclF;
  logic sdaF;
  logic wpOk;
  logic startEv;
  logic stopEv;
  logic sclRise;
  logic sclFall;
  assign sclF    = filt[0];
  assign sdaF    = filt[1];
  assign wpOk    = pin2_r[4];
  assign startEv = sclF & sclP_r & sdaP_r & ~sdaF;
  assign stopEv  = sclF & sclP_r & ~sdaP_r & sdaF;
  assign sclRise = sclF & ~sclP_r;
  assign sclFall = ~sclF & sclP_r;

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  potc_dstate_e st_r;
  logic [7:0]   sh_r;
  logic [3:0]   bitCnt_r;
  logic         sdaOe_r;
  logic         ackSeen_r;
  logic         nvAccept_r;
  logic         busy_r;
  logic         nvWr;
  logic         rdOp;
  assign nvWr = rxInstr[7:potc_pkg::INSTR_OPC_LSB] == potc_pkg::OPC_WR_DR;
  assign rdOp = (rxInstr[7:potc_pkg::INSTR_OPC_LSB] == potc_pkg::OPC_RD_WCR) ||
                (rxInstr[7:potc_pkg::INSTR_OPC_LSB] == potc_pkg::OPC_RD_DR);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r       <= DS_IDLE;
      sh_r       <= 8'h00;
      bitCnt_r   <= 4'h0;
      sdaOe_r    <= 1'b0;
      ackSeen_r  <= 1'b0;
      nvAccept_r <= 1'b0;
      rxInstr    <= 8'h00;
      rxData     <= 8'h00;
      rxStrobe   <= 1'b0;
      txTake     <= 1'b0;
    end else begin
      rxStrobe   <= 1'b0;
      txTake     <= 1'b0;
      nvAccept_r <= 1'b0;
      if (busy_r) begin
        // Deaf while programming, so address polls go unanswered
        st_r    <= DS_IDLE;
        sdaOe_r <= 1'b0;
      end else if (startEv) begin
        st_r     <= DS_ADDR;
        bitCnt_r <= 4'h0;
        sdaOe_r  <= 1'b0;
      end else if (stopEv) begin
        st_r    <= DS_IDLE;
        sdaOe_r <= 1'b0;
      end else begin
        case (st_r)
          DS_ADDR, DS_INSTR, DS_DATA: begin
            if (sclRise) begin
              sh_r     <= {sh_r[6:0], sdaF};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              bitCnt_r <= 4'h0;
              if (st_r == DS_ADDR) begin
                if (sh_r == {potc_pkg::TYPE_CODE, pin2_r[3:0]}) begin
                  sdaOe_r <= 1'b1;
                  st_r    <= DS_ADDR_ACK;
                end else begin
                  st_r <= DS_IDLE;
                end
              end else if (st_r == DS_INSTR) begin
                rxInstr <= sh_r;
                sdaOe_r <= 1'b1;
                st_r    <= DS_INSTR_ACK;
              end else if (nvWr && !wpOk) begin
                st_r <= DS_IDLE;
              end else begin
                rxData     <= sh_r;
                rxStrobe   <= 1'b1;
                nvAccept_r <= nvWr;
                sdaOe_r    <= 1'b1;
                st_r       <= DS_DATA_ACK;
              end
            end
          end
          DS_ADDR_ACK, DS_DATA_ACK: begin
            if (sclFall) begin
              sdaOe_r <= 1'b0;
              st_r    <= (st_r == DS_ADDR_ACK) ? DS_INSTR : DS_DATA;
            end
          end
          DS_INSTR_ACK, DS_TX_ACK: begin
            if (sclRise) begin
              ackSeen_r <= ~sdaF;
            end else if (sclFall) begin
              if ((st_r == DS_INSTR_ACK && rdOp) || (st_r == DS_TX_ACK && ackSeen_r)) begin
                sh_r     <= txByte;
                sdaOe_r  <= ~txByte[7];
                txTake   <= 1'b1;
                bitCnt_r <= 4'h1;
                st_r     <= DS_TX;
              end else begin
                sdaOe_r <= 1'b0;
                // A write moves on to data; after the master's NACK, stay released until the next START
                st_r    <= (st_r == DS_INSTR_ACK) ? DS_DATA : DS_IDLE;
              end
            end
          end
          DS_TX: begin
            if (sclFall) begin
              if (bitCnt_r == 4'h8) begin
                sdaOe_r  <= 1'b0;
                bitCnt_r <= 4'h0;
                st_r     <= DS_TX_ACK;
              end else begin
                sdaOe_r  <= ~sh_r[6];
                sh_r     <= {sh_r[6:0], 1'b0};
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          default: begin
            st_r <= DS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Nonvolatile programming cycle
  // ----------------------------------------
  logic        pend_r;
  logic [19:0] progCnt_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 1'b0;
    end else if (!wpOk) begin
      pend_r <= 1'b0;
    end else if (nvAccept_r) begin
      pend_r <= 1'b1;
    end else if (stopEv) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_r    <= 1'b0;
      progCnt_r <= 20'h00000;
    end else if (busy_r) begin
      // Protect falling now no longer matters
      if (progCnt_r == 20'(PROG_CYCLES - 1)) begin
        busy_r <= 1'b0;
      end
      progCnt_r <= progCnt_r + 20'h00001;
    end else if (stopEv && pend_r && wpOk) begin
      busy_r    <= 1'b1;
      progCnt_r <= 20'h00000;
    end
  end

  logic sdaOut_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdaOut_r <= 1'b0;
    end else begin
      sdaOut_r <= 1'b0;
    end
  end

  assign bus.sdaDevOe  = sdaOe_r;
  assign bus.sdaDevOut = sdaOut_r;
  assign progBusy      = busy_r;
endmodule

// >>> src/potc_mst_end.sv
`timescale 1ns/10ps
module potc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          push;
  logic          pop;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outValid = cnt_r != '0;
  assign outData  = mem[rp_r];
  assign cnt_nxt  = cnt_r + CW'(push) - CW'(pop);

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_r] <= inData;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      inReady <= 1'b1;
    end else begin
      wp_r    <= push ? AW'((32'(wp_r) + 1) % D) : wp_r;
      rp_r    <= pop ? AW'((32'(rp_r) + 1) % D) : rp_r;
      cnt_r   <= cnt_nxt;
      inReady <= 32'(cnt_nxt) < D;
    end
  end
endmodule

module potc_mst_end #(
  parameter int PWRUP_CYCLES = potc_pkg::PWRUP_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Two-wire bus
  potc_bus_if.mst          bus,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdata,
  output logic             cmdReady
);
  typedef enum {MS_IDLE, MS_RUN} potc_mstate_e;

  // ----------------------------------------
  // Command queue
  // ----------------------------------------
  logic                       qValid;
  logic                       qReady;
  logic [potc_pkg::CMD_W-1:0] qData;
  potc_fifo #(.W(potc_pkg::CMD_W), .D(potc_pkg::FIFO_DEPTH)) uFifo (
    .clock    (clock),
    .rstn     (rstn),
    .inValid  (regWr && regAddr == potc_pkg::REG_CMD),
    .inReady  (cmdReady),
    .inData   (regWdata[potc_pkg::CMD_W-1:0]),
    .outValid (qValid),
    .outReady (qReady),
    .outData  (qData)
  );

  // ----------------------------------------
  // Power-up hold-off and SDA sampling
  // ----------------------------------------
  logic [16:0] pwrCnt_r;
  logic        pwrDone_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwrCnt_r  <= 17'h00000;
      pwrDone_r <= 1'b0;
    end else if (!pwrDone_r) begin
      pwrCnt_r  <= pwrCnt_r + 17'h00001;
      pwrDone_r <= pwrCnt_r == 17'(PWRUP_CYCLES - 1);
    end
  end

  logic sda1_r;
  logic sda2_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sda1_r <= 1'b1;
      sda2_r <= 1'b1;
    end else begin
      sda1_r <= bus.sda;
      sda2_r <= sda1_r;
    end
  end

  // ----------------------------------------
  // Bit engine: four quarters per SCL period
  // ----------------------------------------
  potc_mstate_e st_r;
  logic [2:0]   op_r;
  logic [7:0]   byte_r;
  logic [7:0]   rx_r;
  logic [3:0]   idx_r;
  logic [1:0]   q_r;
  logic [6:0]   qCnt_r;
  logic         sclOe_r;
  logic         sdaOe_r;
  logic         ack_r;
  logic         isBit;
  assign qReady = st_r == MS_IDLE && pwrDone_r;
  assign isBit  = op_r != potc_pkg::CMD_START && op_r != potc_pkg::CMD_STOP;

  function automatic logic drvLow(logic [2:0] op, logic [7:0] b, logic [3:0] i);
    if (op == potc_pkg::CMD_WRITE) begin
      drvLow = (i < 4'h8) ? ~b[3'(4'h7 - i)] : 1'b0;
    end else begin
      drvLow = (i == 4'h8) && (op == potc_pkg::CMD_READ_ACK);
    end
  endfunction

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r    <= MS_IDLE;
      op_r    <= potc_pkg::CMD_START;
      byte_r  <= 8'h00;
      rx_r    <= 8'h00;
      idx_r   <= 4'h0;
      q_r     <= 2'h0;
      qCnt_r  <= 7'h00;
      sclOe_r <= 1'b0;
      sdaOe_r <= 1'b0;
      ack_r   <= 1'b0;
    end else begin
      case (st_r)
        MS_IDLE: begin
          if (qValid && qReady) begin
            op_r    <= qData[10:8];
            byte_r  <= qData[7:0];
            idx_r   <= 4'h0;
            q_r     <= 2'h0;
            qCnt_r  <= 7'h00;
            st_r    <= MS_RUN;
            // SCL low first, so SDA only moves while SCL is low
            sclOe_r <= 1'b1;
            if (qData[10:8] == potc_pkg::CMD_STOP) begin
              sdaOe_r <= 1'b1;
            end else if (qData[10:8] == potc_pkg::CMD_START) begin
              sdaOe_r <= 1'b0;
            end else begin
              sdaOe_r <= drvLow(qData[10:8], qData[7:0], 4'h0);
            end
          end
        end
        MS_RUN: begin
          if (qCnt_r != 7'(potc_pkg::QTR_CYC - 1)) begin
            qCnt_r <= qCnt_r + 7'h01;
          end else begin
            qCnt_r <= 7'h00;
            q_r    <= q_r + 2'h1;
            case (q_r)
              2'h0: begin
                sclOe_r <= 1'b0;
              end
              2'h1: begin
                if (op_r == potc_pkg::CMD_START) begin
                  sdaOe_r <= 1'b1;
                end else if (op_r == potc_pkg::CMD_STOP) begin
                  sdaOe_r <= 1'b0;
                end
              end
              2'h2: begin
                sclOe_r <= op_r != potc_pkg::CMD_STOP;
                if (isBit && idx_r < 4'h8) begin
                  rx_r <= {rx_r[6:0], sda2_r};
                end else if (isBit) begin
                  ack_r <= ~sda2_r;
                end
              end
              default: begin
                if (!isBit || idx_r == 4'h8) begin
                  st_r <= MS_IDLE;
                  if (isBit) begin
                    sdaOe_r <= 1'b0;
                  end
                end else begin
                  idx_r   <= idx_r + 4'h1;
                  sdaOe_r <= drvLow(op_r, byte_r, idx_r + 4'h1);
                end
              end
            endcase
          end
        end
        default: begin
          st_r <= MS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status read, one cycle after the strobe
  // ----------------------------------------
  logic outZero_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regRdata  <= 16'h0000;
      outZero_r <= 1'b0;
    end else begin
      outZero_r <= 1'b0;
      regRdata  <= 16'h0000;
      if (regRd && regAddr == potc_pkg::REG_STATUS) begin
        regRdata[7:0]                  <= rx_r;
        regRdata[potc_pkg::ST_ACK_BIT]   <= ack_r;
        regRdata[potc_pkg::ST_BUSY_BIT]  <= st_r != MS_IDLE;
        regRdata[potc_pkg::ST_EMPTY_BIT] <= ~qValid;
        regRdata[potc_pkg::ST_READY_BIT] <= cmdReady;
        regRdata[potc_pkg::ST_PWR_BIT]   <= pwrDone_r;
      end
    end
  end

  assign bus.sclMstOe  = sclOe_r;
  assign bus.sdaMstOe  = sdaOe_r;
  assign bus.sclMstOut = outZero_r;
  assign bus.sdaMstOut = outZero_r;
endmodule

// >>> tb/potc_props.sv
`timescale 1ns/10ps
module potc_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Bus drivers and wires
  input wire logic sclMstOut,
  input wire logic sclMstOe,
  input wire logic sdaMstOut,
  input wire logic sdaMstOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // Start and stop seen on the raw wires
  // ----------------------------------------
  logic sclDly_r;
  logic sdaDly_r;
  logic seen_r;
  logic startEv;
  logic stopEv;

  assign startEv = sclDly_r & scl & sdaDly_r & ~sda;
  assign stopEv  = sclDly_r & scl & ~sdaDly_r & sda;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclDly_r <= 1'b1;
      sdaDly_r <= 1'b1;
    end else begin
      sclDly_r <= scl;
      sdaDly_r <= sda;
    end
  end

  // Device may only drive inside a frame opened by a start
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seen_r <= 1'b0;
    end else if (startEv) begin
      seen_r <= 1'b1;
    end else if (stopEv) begin
      seen_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_open_drain_low: assert property (!sclMstOut && !sdaMstOut && !sdaDevOut)
    else $error("a driver output is not low");
  a_drive_after_start: assert property (sdaDevOe |-> seen_r)
    else $error("device drives SDA outside a frame");
  a_release_at_stop: assert property (stopEv |=> !sdaDevOe [*8])
    else $error("device drives SDA after stop");
  a_dev_scl_low: assert property ($changed(sdaDevOe) |-> !scl)
    else $error("device moved SDA while SCL high");
  a_dev_bit_hold: assert property ($rose(sdaDevOe) |-> sdaDevOe [*8])
    else $error("device low bit too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("SCL low phase too short");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("SCL high phase too short");
  a_start_hold: assert property (startEv |-> scl [*8])
    else $error("SCL fell too soon after start");

  c_start: cover property (startEv);
  c_stop: cover property (stopEv);
  c_dev_ack: cover property ($rose(sdaDevOe));
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam int         PROG     = 2000;
  localparam logic [7:0] DEV_ADDR = {potc_pkg::TYPE_CODE, 4'h6};
  localparam int         ACK      = potc_pkg::ST_ACK_BIT;

  logic        clock      = 1'b0;
  logic        rstn       = 1'b0;
  logic [3:0]  regAddr    = 4'h0;
  logic [15:0] regWdata   = 16'h0000;
  logic        regWr      = 1'b0;
  logic        regRd      = 1'b0;
  logic [15:0] regRdata;
  logic        cmdReady;
  logic [3:0]  strap      = 4'h6;
  logic        writeAllow = 1'b1;
  logic [7:0]  txByte     = 8'h5c;
  logic        txTake;
  logic [7:0]  rxInstr;
  logic [7:0]  rxData;
  logic        rxStrobe;
  logic        progBusy;
  logic [15:0] st;
  logic [7:0]  bad [2]    = '{8'h56, 8'ha7};
  int          num_errors = 0;
  int          tests_run  = 0;
  int          strobes    = 0;
  int          busyCyc    = 0;

  always #5 clock = ~clock;

  potc_bus_if i_potc_bus_if ();

  potc_dev_end #(.PROG_CYCLES(PROG)) i_potc_dev_end (
    .clock(clock), .rstn(rstn), .bus(i_potc_bus_if),
    .addrStrapBit0(strap[0]), .addrStrapBit1(strap[1]),
    .addrStrapBit2(strap[2]), .addrStrapBit3(strap[3]),
    .writeAllow(writeAllow), .txByte(txByte), .txTake(txTake), .rxInstr(rxInstr),
    .rxData(rxData), .rxStrobe(rxStrobe), .progBusy(progBusy));

  potc_mst_end #(.PWRUP_CYCLES(20)) i_potc_mst_end (
    .clock(clock), .rstn(rstn), .bus(i_potc_bus_if), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .cmdReady(cmdReady));

  potc_props i_potc_props (
    .clock(clock), .rstn(rstn), .sclMstOut(i_potc_bus_if.sclMstOut),
    .sclMstOe(i_potc_bus_if.sclMstOe), .sdaMstOut(i_potc_bus_if.sdaMstOut),
    .sdaMstOe(i_potc_bus_if.sdaMstOe), .sdaDevOut(i_potc_bus_if.sdaDevOut),
    .sdaDevOe(i_potc_bus_if.sdaDevOe), .scl(i_potc_bus_if.scl), .sda(i_potc_bus_if.sda));

  // Next byte is offered as soon as the device takes one
  always @(posedge clock) begin
    if (txTake === 1'b1) txByte <= 8'ha3;
    if (rxStrobe === 1'b1) strobes <= strobes + 1;
    if (progBusy === 1'b1) busyCyc <= busyCyc + 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clock);
    regWr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clock);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // A polling loop is bounded: running out ends the run as a failure
  task automatic wait_idle();
    for (int n = 0; n < 20000; n++) begin
      reg_rd(potc_pkg::REG_STATUS, st);
      if (st[potc_pkg::ST_BUSY_BIT] === 1'b0 && st[potc_pkg::ST_EMPTY_BIT] === 1'b1) return;
    end
    num_errors++;
    final_report();
  endtask

  task automatic xb(input logic [2:0] op, input logic [7:0] b);
    reg_wr(potc_pkg::REG_CMD, {5'h00, op, b});
    wait_idle();
  endtask

  task automatic poll(input logic [7:0] a, input logic ok);
    xb(potc_pkg::CMD_START, 8'h00);
    xb(potc_pkg::CMD_WRITE, a);
    check("address ack", 16'(st[ACK]), 16'(ok));
  endtask

  task automatic wr3(input logic [7:0] ins, input logic [7:0] dat, input logic ok);
    poll(DEV_ADDR, 1'b1);
    xb(potc_pkg::CMD_WRITE, ins);
    check("instruction ack", 16'(st[ACK]), 16'h1);
    xb(potc_pkg::CMD_WRITE, dat);
    check("data ack", 16'(st[ACK]), 16'(ok));
    xb(potc_pkg::CMD_STOP, 8'h00);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    reg_rd(potc_pkg::REG_STATUS, st);
    check("power-up early", 16'(st[potc_pkg::ST_PWR_BIT]), 16'h0);
    check("fifo empty", 16'(st[potc_pkg::ST_EMPTY_BIT]), 16'h1);
    reg_rd(4'h8, st);
    check("unmapped read", st, 16'h0000);
    repeat (30) @(posedge clock);
    reg_rd(potc_pkg::REG_STATUS, st);
    check("power-up done", 16'(st[potc_pkg::ST_PWR_BIT]), 16'h1);
    $display("test reset done");
    foreach (bad[i]) begin
      poll(bad[i], 1'b0);
      xb(potc_pkg::CMD_WRITE, 8'h00);
      check("after mismatch", 16'(st[ACK]), 16'h0);
      xb(potc_pkg::CMD_STOP, 8'h00);
    end
    $display("test address done");
    wr3(8'ha5, 8'h3c, 1'b1);
    check("instruction", 16'(rxInstr), 16'h00a5);
    check("data", 16'(rxData), 16'h003c);
    check("strobes", 16'(strobes), 16'h1);
    check("volatile busy", 16'(progBusy), 16'h0);
    $display("test volatile write done");
    wr3(8'hc6, 8'h2b, 1'b1);
    check("programming", 16'(progBusy), 16'h1);
    @(posedge clock);
    writeAllow <= 1'b0;
    poll(DEV_ADDR, 1'b0);
    xb(potc_pkg::CMD_STOP, 8'h00);
    poll(DEV_ADDR, 1'b1);
    xb(potc_pkg::CMD_STOP, 8'h00);
    check("program length", 16'(busyCyc), 16'(PROG));
    $display("test programming done");
    // Protect is still low from the previous test
    wr3(8'hc1, 8'h11, 1'b0);
    check("protected data", 16'(rxData), 16'h002b);
    check("protected strobes", 16'(strobes), 16'h2);
    check("no programming", 16'(busyCyc), 16'(PROG));
    @(posedge clock);
    writeAllow <= 1'b1;
    // Protect falling between data and stop must drop the pending write
    poll(DEV_ADDR, 1'b1);
    xb(potc_pkg::CMD_WRITE, 8'hc2);
    xb(potc_pkg::CMD_WRITE, 8'h44);
    check("late protect ack", 16'(st[ACK]), 16'h1);
    @(posedge clock);
    writeAllow <= 1'b0;
    xb(potc_pkg::CMD_STOP, 8'h00);
    check("abandoned write", 16'(busyCyc), 16'(PROG));
    @(posedge clock);
    writeAllow <= 1'b1;
    $display("test protect done");
    poll(DEV_ADDR, 1'b1);
    xb(potc_pkg::CMD_WRITE, 8'h91);
    xb(potc_pkg::CMD_READ_ACK, 8'h00);
    check("first read", 16'(st[7:0]), 16'h005c);
    xb(potc_pkg::CMD_READ_NACK, 8'h00);
    check("second read", 16'(st[7:0]), 16'h00a3);
    xb(potc_pkg::CMD_STOP, 8'h00);
    // The data register read opcode must also switch the device to sending
    poll(DEV_ADDR, 1'b1);
    xb(potc_pkg::CMD_WRITE, 8'hb6);
    xb(potc_pkg::CMD_READ_NACK, 8'h00);
    check("register read", 16'(st[7:0]), 16'h00a3);
    xb(potc_pkg::CMD_STOP, 8'h00);
    $display("test read done");
    // Ten pushes against a slow engine overrun the eight-word queue
    reg_wr(potc_pkg::REG_CMD, {5'h00, potc_pkg::CMD_START, 8'h00});
    repeat (9) reg_wr(potc_pkg::REG_CMD, {5'h00, potc_pkg::CMD_WRITE, 8'hff});
    reg_rd(potc_pkg::REG_STATUS, st);
    check("fifo full", 16'(st[potc_pkg::ST_READY_BIT]), 16'h0);
    check("ready low", 16'(cmdReady), 16'h0);
    wait_idle();
    xb(potc_pkg::CMD_STOP, 8'h00);
    check("fifo drained", 16'(st[potc_pkg::ST_READY_BIT]), 16'h1);
    $display("test fifo done");
    final_report();
  end
endmodule
